// ==== core/sync_rx_pkg.sv ====
package sync_rx_pkg;

    // register byte addresses (chosen layout)
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET   = 8'h08;
    localparam logic [7:0] BAUD_OFFSET   = 8'h0C;

    // control register fields
    localparam int CTRL_PORT_EN_BIT   = 0;
    localparam int CTRL_MASTER_BIT    = 1;
    localparam int CTRL_SINGLE_BIT    = 2;
    localparam int CTRL_CONT_BIT      = 3;
    localparam int CTRL_NINTH_BIT     = 4;

    // status register fields
    localparam int STAT_PENDING_BIT   = 0;
    localparam int STAT_OVERRUN_BIT   = 1;
    localparam int STAT_NINTH_BIT     = 2;
    localparam int STAT_COUNT_LSB     = 3;
    localparam int STAT_BUSY_BIT      = 5;

    // reset values and character geometry
    localparam logic [4:0]  CTRL_RESET    = 5'h00;
    localparam logic [15:0] BAUD_RESET    = 16'h0004;
    localparam int          BITS_NORMAL   = 8;
    localparam int          BITS_NINTH    = 9;
    localparam int          FIFO_DEPTH    = 2;

endpackage : sync_rx_pkg

// ==== core/pin_sync.sv ====
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // pin side
    input  wire logic pinIn,
    // synchronous side
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } state_t;

    state_t st;
    state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.lvl = st.s3;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
    assign rise  = next_st.lvl & ~st.lvl;
    assign fall  = ~next_st.lvl & st.lvl;

endmodule : pin_sync

// ==== core/sync_serial_receiver.sv ====
// Operation
// - reception starts only with single or continuous enable
// - master single: one character of clocks, self-clear
// - continuous enable keeps clocks running without pause
// - continuous cleared midway stops clock, drops character
// - both set: single cleared after first character
// - data sampled on trailing clock edge, shifted in
// - full character sets pending, enters two-entry fifo
// - data port shows low eight bits of oldest
// - pending stays set while fifo holds unread characters
// - slave takes clock from pin, driver off
// - transmitter changes data on leading edge
// - one data bit per clock cycle
// - third character with full fifo sets overrun
// - overrun keeps stored characters, accepts nothing new
// - overrun clears on condition removal; single: data read
// - continuous overrun clears on continuous or port disable
// - ninth-bit mode shifts nine bits per character
module sync_serial_receiver (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial pins
    input  wire logic        syncDataPinIn,
    output logic             syncDataPinOut,
    output logic             syncDataPinOe,
    input  wire logic        syncClockPinIn,
    output logic             syncClockPinOut,
    output logic             syncClockPinOe
);
    typedef enum logic [2:0] {
        IDLE  = 3'b001,
        LOW   = 3'b010,
        HIGH  = 3'b100
    } phase_t;

    typedef struct packed {
        logic        portEnable;
        logic        clockMaster;
        logic        singleReceiveEnable;
        logic        continuousReceiveEnable;
        logic        ninthBitEnable;
        logic [15:0] baudDivisor;
        phase_t      phase;
        logic [15:0] baudCount;
        logic [3:0]  bitCount;
        logic [8:0]  rxShiftRegister;
        logic [8:0]  fifoMem0;
        logic [8:0]  fifoMem1;
        logic [1:0]  fifoCount;
        logic        overrunErrorFlag;
        logic        overrunInSingle;
        logic        clockOut;
        logic [31:0] readData;
    } state_t;

    state_t st;
    state_t next_st;

    logic clkFall;
    logic dataLevel;

    // data and clock pass like synchronisers, but the fall strobe comes from next state, one cycle ahead of the registered data level
    pin_sync uClockSync (
        .clk   (clk),
        .rstn  (rstn),
        .pinIn (syncClockPinIn),
        .level (),
        .rise  (),
        .fall  (clkFall)
    );

    pin_sync uDataSync (
        .clk   (clk),
        .rstn  (rstn),
        .pinIn (syncDataPinIn),
        .level (dataLevel),
        .rise  (),
        .fall  ()
    );

    logic       apbWrite;
    logic       apbRead;
    logic       apbSetupRead;
    logic       dataRead;
    logic       enabled;
    logic       trailingEdge;
    logic [3:0] charBits;
    logic [8:0] sampled;
    logic       charDone;
    logic       receivePendingFlag;
    logic       busy;

    always_comb begin
        apbWrite = psel & penable & pwrite;
        apbRead  = psel & penable & ~pwrite;
        apbSetupRead = psel & ~penable & ~pwrite;
        dataRead = apbRead & (paddr == sync_rx_pkg::DATA_OFFSET);
        enabled  = st.portEnable & (st.singleReceiveEnable | st.continuousReceiveEnable);
        charBits = st.ninthBitEnable ? 4'(sync_rx_pkg::BITS_NINTH)
                                     : 4'(sync_rx_pkg::BITS_NORMAL);
        receivePendingFlag = (st.fifoCount != 2'h0);
        busy = (st.phase != IDLE);
        // trailing edge: master makes it when its clock falls, slave sees pin fall
        trailingEdge = 1'b0;
        if (st.clockMaster) begin
            trailingEdge = (st.phase == HIGH) && (st.baudCount == 16'h0000);
        end else if (enabled && !st.overrunErrorFlag) begin
            trailingEdge = clkFall;
        end
        sampled = {dataLevel, st.rxShiftRegister[8:1]};
        charDone = trailingEdge && (st.bitCount == charBits - 4'h1);
    end

    always_comb begin
        next_st = st;
        next_st.readData = 32'h0000_0000;

        // register writes
        if (apbWrite && paddr == sync_rx_pkg::CTRL_OFFSET) begin
            next_st.portEnable              = pwdata[sync_rx_pkg::CTRL_PORT_EN_BIT];
            next_st.clockMaster             = pwdata[sync_rx_pkg::CTRL_MASTER_BIT];
            next_st.singleReceiveEnable     = pwdata[sync_rx_pkg::CTRL_SINGLE_BIT];
            next_st.continuousReceiveEnable = pwdata[sync_rx_pkg::CTRL_CONT_BIT];
            next_st.ninthBitEnable          = pwdata[sync_rx_pkg::CTRL_NINTH_BIT];
        end
        if (apbWrite && paddr == sync_rx_pkg::BAUD_OFFSET) begin
            next_st.baudDivisor = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        end

        // bit clock generation and sampling
        if (!enabled || st.overrunErrorFlag) begin
            // partial character is dropped and the clock parks low
            next_st.phase     = IDLE;
            next_st.bitCount  = 4'h0;
            next_st.baudCount = 16'h0000;
            next_st.clockOut  = 1'b0;
        end else if (st.clockMaster) begin
            case (st.phase)
                IDLE: begin
                    next_st.phase     = LOW;
                    next_st.baudCount = st.baudDivisor - 16'h0001;
                end
                LOW: begin
                    if (st.baudCount == 16'h0000) begin
                        next_st.phase     = HIGH;
                        next_st.clockOut  = 1'b1;
                        next_st.baudCount = st.baudDivisor - 16'h0001;
                    end else begin
                        next_st.baudCount = st.baudCount - 16'h0001;
                    end
                end
                HIGH: begin
                    if (st.baudCount == 16'h0000) begin
                        next_st.clockOut  = 1'b0;
                        next_st.baudCount = st.baudDivisor - 16'h0001;
                        // continuous keeps running; single stops after one character
                        next_st.phase = (charDone && !st.continuousReceiveEnable)
                                        ? IDLE : LOW;
                    end else begin
                        next_st.baudCount = st.baudCount - 16'h0001;
                    end
                end
                default: begin
                    next_st.phase = IDLE;
                end
            endcase
        end else begin
            next_st.phase = LOW;
        end

        if (trailingEdge) begin
            next_st.rxShiftRegister = sampled;
            next_st.bitCount        = charDone ? 4'h0 : st.bitCount + 4'h1;
        end

        // fifo read pops the oldest entry
        if (dataRead && st.fifoCount != 2'h0) begin
            next_st.fifoMem0  = st.fifoMem1;
            next_st.fifoCount = st.fifoCount - 2'h1;
        end

        if (charDone) begin
            // nine-bit character lands right-justified
            if (st.fifoCount == 2'(sync_rx_pkg::FIFO_DEPTH) && !dataRead) begin
                next_st.overrunErrorFlag = 1'b1;
                next_st.overrunInSingle  = ~st.continuousReceiveEnable;
            end else begin
                if (next_st.fifoCount == 2'h0) begin
                    next_st.fifoMem0 = st.ninthBitEnable ? sampled : {1'b0, sampled[8:1]};
                end else begin
                    next_st.fifoMem1 = st.ninthBitEnable ? sampled : {1'b0, sampled[8:1]};
                end
                next_st.fifoCount = next_st.fifoCount + 2'h1;
            end
            if (st.singleReceiveEnable) begin
                next_st.singleReceiveEnable = 1'b0;
            end
        end

        // overrun clearing
        if (st.overrunErrorFlag) begin
            if (st.overrunInSingle && dataRead) begin
                next_st.overrunErrorFlag = 1'b0;
            end
            if (!st.overrunInSingle && !next_st.continuousReceiveEnable) begin
                next_st.overrunErrorFlag = 1'b0;
            end
        end

        // clearing the port enable empties the fifo and clears overrun and both receive enables
        if (!next_st.portEnable) begin
            next_st.fifoCount               = 2'h0;
            next_st.overrunErrorFlag        = 1'b0;
            next_st.singleReceiveEnable     = 1'b0;
            next_st.continuousReceiveEnable = 1'b0;
        end

        // read word captured at the setup edge so it stands through the access cycle
        if (apbSetupRead) begin
            case (paddr)
                sync_rx_pkg::CTRL_OFFSET: begin
                    next_st.readData = {27'h0, st.ninthBitEnable,
                                        st.continuousReceiveEnable,
                                        st.singleReceiveEnable,
                                        st.clockMaster, st.portEnable};
                end
                sync_rx_pkg::STATUS_OFFSET: begin
                    next_st.readData = {26'h0, busy, st.fifoCount,
                                        st.fifoMem0[8],
                                        st.overrunErrorFlag, receivePendingFlag};
                end
                sync_rx_pkg::DATA_OFFSET: begin
                    next_st.readData = {24'h0, st.fifoMem0[7:0]};
                end
                sync_rx_pkg::BAUD_OFFSET: begin
                    next_st.readData = {16'h0, st.baudDivisor};
                end
                default: begin
                    next_st.readData = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st             <= '0;
            st.phase       <= IDLE;
            st.baudDivisor <= sync_rx_pkg::BAUD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // apb: zero wait states; the read word was prepared during setup
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = st.readData;

    // slave mode leaves the clock pin undriven, receive never drives data
    assign syncClockPinOut = st.clockOut;
    assign syncClockPinOe  = st.portEnable & st.clockMaster;
    assign syncDataPinOut  = 1'b0;
    assign syncDataPinOe   = 1'b0;

endmodule : sync_serial_receiver

// ==== testbench/sync_rx_props.sv ====
module sync_rx_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // pins
    input wire logic        syncDataPinOe,
    input wire logic        syncClockPinOut,
    input wire logic        syncClockPinOe
);
    logic [4:0]  ctrlW;
    logic [15:0] baudW;
    logic [15:0] highLen;
    logic [7:0]  fallCnt;
    logic        cut;
    logic        wrCtrl;
    logic        wrBaud;
    assign wrCtrl = psel && penable && pwrite && paddr == sync_rx_pkg::CTRL_OFFSET;
    assign wrBaud = psel && penable && pwrite && paddr == sync_rx_pkg::BAUD_OFFSET;
    // mirror of software writes; the self-clearing single bit only narrows activity
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlW   <= 5'h00;
            baudW   <= 16'h0004;
            highLen <= 16'h0000;
            fallCnt <= 8'h00;
            cut     <= 1'b1;
        end else begin
            if (wrCtrl) ctrlW <= pwdata[4:0];
            if (wrBaud) baudW <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
            highLen <= syncClockPinOut ? highLen + 16'h0001 : 16'h0000;
            fallCnt <= wrCtrl ? 8'h00 : fallCnt + {7'h00, $fell(syncClockPinOut)};
            // a setting change may cut a high phase short
            cut     <= wrCtrl || wrBaud || (cut && !$rose(syncClockPinOut));
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_read;
        psel && !penable && !pwrite;
    endsequence
    sequence s_bad_read;
        s_read ##0 (paddr > sync_rx_pkg::BAUD_OFFSET);
    endsequence
    sequence s_off;
        !ctrlW[sync_rx_pkg::CTRL_SINGLE_BIT] && !ctrlW[sync_rx_pkg::CTRL_CONT_BIT];
    endsequence
    property p_no_start;
        s_off ##0 !syncClockPinOut |=> !syncClockPinOut;
    endproperty
    property p_clk_oe;
        syncClockPinOe == (ctrlW[sync_rx_pkg::CTRL_PORT_EN_BIT]
                           && ctrlW[sync_rx_pkg::CTRL_MASTER_BIT]);
    endproperty
    property p_half;
        syncClockPinOe && $fell(syncClockPinOut) && !cut |-> highLen == baudW;
    endproperty
    property p_burst;
        ctrlW[sync_rx_pkg::CTRL_SINGLE_BIT] && !ctrlW[sync_rx_pkg::CTRL_CONT_BIT]
            |-> fallCnt <= (ctrlW[sync_rx_pkg::CTRL_NINTH_BIT] ? 8'h09 : 8'h08);
    endproperty
    property p_port_off;
        !ctrlW[sync_rx_pkg::CTRL_PORT_EN_BIT] |=> !syncClockPinOut;
    endproperty
    property p_data_oe;
        !syncDataPinOe;
    endproperty
    property p_ready;
        pready && !pslverr;
    endproperty
    property p_release;
        !(psel && !penable && !pwrite) |=> prdata == 32'h0;
    endproperty
    property p_unmapped;
        s_bad_read |=> prdata == 32'h0;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("bit clock rose with reception disabled");
    a_clk_oe: assert property (p_clk_oe)
        else $error("clock pin driver state wrong");
    a_half: assert property (p_half)
        else $error("bit clock high phase not the programmed length");
    a_burst: assert property (p_burst)
        else $error("single reception gave too many clocks");
    a_port_off: assert property (p_port_off)
        else $error("bit clock active with port disabled");
    a_data_oe: assert property (p_data_oe)
        else $error("data pin driven while receiving");
    a_ready: assert property (p_ready)
        else $error("bus answer not ready or flagged error");
    a_release: assert property (p_release)
        else $error("read word held beyond its cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");
endmodule : sync_rx_props

bind sync_serial_receiver sync_rx_props sync_rx_props_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .syncDataPinOe(syncDataPinOe), .syncClockPinOut(syncClockPinOut),
    .syncClockPinOe(syncClockPinOe));

// ==== testbench/sync_tx_model.sv ====
module sync_tx_model (
    // shared clock wire and control
    input  wire logic       bitClk,
    input  wire logic       load,
    input  wire logic       go,
    input  wire logic       ninth,
    input  wire logic [8:0] loadWord,
    // driven lines
    output logic            dataLine,
    output logic            linkClk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] word;
    int         cnt;
    initial begin
        dataLine = 1'b0;
        linkClk  = 1'b0;
        word     = 9'h000;
        cnt      = 0;
    end
    always @(posedge load) begin
        word = loadWord;
        cnt  = 0;
    end
    // next bit, lsb first, on every leading edge; the word counts up per character
    always @(posedge bitClk) begin
        dataLine = word[cnt];
        cnt++;
        if (cnt == (ninth ? 9 : 8)) begin
            cnt  = 0;
            word = word + 9'h001;
        end
    end
    // clock master role: two whole characters, clock still between bursts
    always @(posedge go) begin
        #13;
        repeat (ninth ? 18 : 16) begin
            linkClk = 1'b1;
            #80;
            linkClk = 1'b0;
            #80;
        end
        // hold time spent: scramble so a stale bit never reads as valid
        #60;
        dataLine = ~dataLine;
    end
endmodule : sync_tx_model

// ==== testbench/tb_sync_serial_receiver.sv ====
module tb_sync_serial_receiver;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  AC  = sync_rx_pkg::CTRL_OFFSET;
    localparam logic [7:0]  AS  = sync_rx_pkg::STATUS_OFFSET;
    localparam logic [7:0]  AD  = sync_rx_pkg::DATA_OFFSET;
    localparam logic [7:0]  AB  = sync_rx_pkg::BAUD_OFFSET;
    localparam logic [31:0] EN  = 32'h1 << sync_rx_pkg::CTRL_PORT_EN_BIT;
    localparam logic [31:0] MST = 32'h1 << sync_rx_pkg::CTRL_MASTER_BIT;
    localparam logic [31:0] SGL = 32'h1 << sync_rx_pkg::CTRL_SINGLE_BIT;
    localparam logic [31:0] CNT = 32'h1 << sync_rx_pkg::CTRL_CONT_BIT;
    localparam logic [31:0] NIN = 32'h1 << sync_rx_pkg::CTRL_NINTH_BIT;
    localparam int          NB  = sync_rx_pkg::STAT_NINTH_BIT;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        load = 1'b0;
    logic        go = 1'b0;
    logic        ninth = 1'b0;
    logic [8:0]  loadWord = 9'h000;
    logic        pready, pslverr, dataLine, linkClk, clkOut, clkOe, clkWire;
    logic [31:0] prdata, rd;
    logic [8:0]  w;
    int          badCount, checksDone, seed;
    always #10 clk = ~clk;
    // the clock pin wire: the device when it drives, else the external master
    assign clkWire = clkOe ? clkOut : linkClk;
    sync_serial_receiver sync_serial_receiver_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .syncDataPinIn(dataLine), .syncDataPinOut(),
        .syncDataPinOe(), .syncClockPinIn(clkWire), .syncClockPinOut(clkOut),
        .syncClockPinOe(clkOe));
    sync_tx_model sync_tx_model_i (
        .bitClk(clkWire), .load(load), .go(go), .ninth(ninth),
        .loadWord(loadWord), .dataLine(dataLine), .linkClk(linkClk));
    function automatic logic [31:0] st(input int p, input int o, input int n);
        return (32'(p) << sync_rx_pkg::STAT_PENDING_BIT)
             | (32'(o) << sync_rx_pkg::STAT_OVERRUN_BIT)
             | (32'(n) << sync_rx_pkg::STAT_COUNT_LSB);
    endfunction : st
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        // read word taken at the edge where pready is sampled high
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask : rdchk
    task automatic waitFor(input logic [7:0] a, input int b, input logic v);
        for (int n = 0; n < 300; n++) begin
            apb(1'b0, a, 32'h0);
            if (rd[b] === v) return;
        end
        check(rd, {rd[31:1], ~rd[0]});
    endtask : waitFor
    task automatic loadTx(input logic [8:0] v);
        loadWord <= v;
        load     <= 1'b1;
        @(posedge clk);
        load     <= 1'b0;
        @(posedge clk);
    endtask : loadTx
    task automatic stopTest;
        $display("Checks %0d, mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stopTest
    initial begin
        #1_000_000;
        badCount++;
        $display("Error at %0t: watchdog expired", $time);
        stopTest;
    end
    initial begin
        seed = 17;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk(AC, 32'h0);
        rdchk(AS, 32'h0);
        rdchk(AB, 32'h4);
        apb(1'b1, 8'h10, $random(seed));
        rdchk(8'h10, 32'h0);
        // the data pin lags by the synchroniser, so a high phase must outlast it
        apb(1'b1, AB, 32'(5 + {$random(seed)} % 4));
        apb(1'b1, AC, EN | MST);
        repeat (50) @(posedge clk);
        rdchk(AS, 32'h0, st(1, 1, 3));
        check({31'h0, clkOe}, 32'h1);
        for (int k = 0; k < 2; k++) begin
            w = 9'($random(seed));
            ninth <= k[0];
            loadTx(w);
            apb(1'b1, AC, EN | MST | SGL | (k[0] ? NIN : 32'h0));
            waitFor(AC, sync_rx_pkg::CTRL_SINGLE_BIT, 1'b0);
            rdchk(AS, st(1, 0, 1) | (32'(w[8] & k[0]) << NB), st(1, 1, 3) | (32'(k) << NB));
            rdchk(AD, {24'h0, w[7:0]});
            rdchk(AS, 32'h0, st(1, 1, 3));
        end
        ninth <= 1'b0;
        w = 9'($random(seed));
        loadTx(w);
        repeat (3) begin
            apb(1'b1, AC, EN | MST | SGL);
            waitFor(AC, sync_rx_pkg::CTRL_SINGLE_BIT, 1'b0);
        end
        rdchk(AS, st(1, 1, 2), st(1, 1, 3));
        rdchk(AD, {24'h0, w[7:0]});
        rdchk(AS, st(1, 0, 1), st(1, 1, 3));
        rdchk(AD, {24'h0, 8'(w + 9'h1)});
        w = 9'($random(seed));
        loadTx(w);
        apb(1'b1, AC, EN | MST | CNT);
        waitFor(AS, sync_rx_pkg::STAT_OVERRUN_BIT, 1'b1);
        apb(1'b1, AC, EN | MST);
        rdchk(AS, st(1, 0, 2), st(1, 1, 3));
        rdchk(AD, {24'h0, w[7:0]});
        rdchk(AD, {24'h0, 8'(w + 9'h1)});
        loadTx(9'($random(seed)));
        apb(1'b1, AC, EN | MST | CNT);
        repeat (3) @(negedge clkOut);
        @(posedge clk);
        apb(1'b1, AC, EN | MST);
        repeat (40) @(posedge clk);
        rdchk(AS, 32'h0, st(1, 1, 3));
        check({31'h0, clkOut}, 32'h0);
        apb(1'b1, AC, EN | CNT);
        check({31'h0, clkOe}, 32'h0);
        w = 9'($random(seed));
        loadTx(w);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        waitFor(AS, sync_rx_pkg::STAT_COUNT_LSB + 1, 1'b1);
        rdchk(AD, {24'h0, w[7:0]});
        apb(1'b1, AC, 32'h0);
        rdchk(AS, 32'h0, st(1, 1, 3));
        stopTest;
    end
endmodule : tb_sync_serial_receiver
